// [hw/adcpd_pkg.sv]
package adcpd_pkg;
    // Command word that requests software power-down
    localparam logic [15:0] ADCPD_CMD_SW_POWER_DOWN_INPUT = 16'h8000;
    localparam int ADCPD_DATA_W = 12;
    localparam logic [11:0] ADCPD_CODE_ZERO = 12'h000;
    localparam logic [11:0] ADCPD_CODE_FULL = 12'hFFF;
    localparam logic [11:0] ADCPD_CFG_RESET = 12'h000;
    localparam int ADCPD_CFG_REF_EXT_BIT = 11;
    // Internal reference warm-up after a full power-down
    localparam int ADCPD_CLK_MHZ = 250;
    localparam int ADCPD_WARMUP_MS = 20;
    localparam int ADCPD_WARMUP_CYCLES = ADCPD_WARMUP_MS * 1000 * ADCPD_CLK_MHZ;

    typedef enum logic [3:0] {
        ADCPD_ACTIVE = 4'h1,
        ADCPD_AUTO = 4'h2,
        ADCPD_SWPD = 4'h4,
        ADCPD_HWPD = 4'h8
    } adcpd_state_t;
endpackage

// [hw/adcpd_ctrl.sv]
`timescale 1ns/1ps
module adcpd_ctrl
    import adcpd_pkg::*;
#(
    parameter int WARMUP_CYCLES = ADCPD_WARMUP_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Wake sources (active low, frame sync active high) and active-low power-down pin
    input wire logic i_chip_select_n,
    input wire logic i_frame_sync_strobe,
    input wire logic i_conversion_start_input_n,
    input wire logic i_power_down_input_n,
    // Command and configuration
    input wire logic i_cmd_valid,
    input wire logic [15:0] i_cmd_word,
    input wire logic i_cfg_write,
    input wire logic [11:0] i_cfg_data,
    input wire logic i_conv_done,
    // Raw conversion and range flags
    input wire logic [11:0] i_raw_code,
    input wire logic i_over_ref_high,
    input wire logic i_under_ref_low,
    // Status
    output logic o_core_on,
    output logic o_ref_on,
    output logic o_ref_ready,
    output logic o_fifo_clear,
    output logic o_sweep_restart,
    output logic [11:0] o_configuration_register,
    output logic [11:0] o_result_code,
    output logic [3:0] o_state
);
    adcpd_state_t state_q;
    adcpd_state_t state_d;
    logic wake;
    logic sw_cmd;
    logic hw_pd;
    logic enter_pd;
    logic [31:0] warm_q;
    logic [11:0] cfg_q;
    logic [11:0] code_q;
    logic pd_pulse_q;
    logic [31:0] ref_run_q;

    // Modes in which the whole chip, reference included, is off
    function automatic logic is_full_pd(input adcpd_state_t s);
        return (s == ADCPD_SWPD) || (s == ADCPD_HWPD);
    endfunction

    // Modes in which the reference keeps running
    function automatic logic ref_kept(input adcpd_state_t s);
        return (s == ADCPD_ACTIVE) || (s == ADCPD_AUTO);
    endfunction

    assign hw_pd = ~i_power_down_input_n;
    assign wake = ~i_chip_select_n | i_frame_sync_strobe | ~i_conversion_start_input_n;
    assign sw_cmd = i_cmd_valid && (i_cmd_word == ADCPD_CMD_SW_POWER_DOWN_INPUT);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ADCPD_ACTIVE: begin
                if (sw_cmd) begin
                    state_d = ADCPD_SWPD;
                end else if (i_conv_done) begin
                    state_d = ADCPD_AUTO;
                end
            end
            ADCPD_AUTO: begin
                if (sw_cmd) begin
                    state_d = ADCPD_SWPD;
                end else if (wake) begin
                    state_d = ADCPD_ACTIVE;
                end
            end
            ADCPD_SWPD: begin
                if (wake) begin
                    state_d = ADCPD_ACTIVE;
                end
            end
            ADCPD_HWPD: begin
                if (sw_cmd) begin
                    state_d = ADCPD_SWPD;
                end else begin
                    state_d = ADCPD_ACTIVE;
                end
            end
            default: state_d = ADCPD_ACTIVE;
        endcase
        if (hw_pd) begin
            state_d = ADCPD_HWPD;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= ADCPD_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    assign enter_pd = is_full_pd(state_d) && !is_full_pd(state_q);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pd_pulse_q <= 1'b0;
        end else begin
            pd_pulse_q <= enter_pd;
        end
    end
    assign o_fifo_clear = pd_pulse_q;
    assign o_sweep_restart = pd_pulse_q;

    // Pin power-down removes power immediately, not waiting for the state register
    assign o_core_on = !hw_pd && (state_q == ADCPD_ACTIVE);
    assign o_ref_on = !hw_pd && ref_kept(state_q);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cfg_q <= ADCPD_CFG_RESET;
        end else if (i_cfg_write && state_q == ADCPD_ACTIVE) begin
            cfg_q <= i_cfg_data;
        end
    end
    assign o_configuration_register = cfg_q;

    // Warm-up count restarts whenever the reference is off
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            warm_q <= 32'h0;
        end else if (!o_ref_on) begin
            warm_q <= 32'h0;
        end else if (warm_q < WARMUP_CYCLES) begin
            warm_q <= warm_q + 32'h1;
        end
    end
    assign o_ref_ready = o_ref_on && (cfg_q[ADCPD_CFG_REF_EXT_BIT] || warm_q >= WARMUP_CYCLES);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            code_q <= ADCPD_CODE_ZERO;
        end else if (i_conv_done) begin
            if (i_over_ref_high) begin
                code_q <= ADCPD_CODE_FULL;
            end else if (i_under_ref_low) begin
                code_q <= ADCPD_CODE_ZERO;
            end else begin
                code_q <= i_raw_code;
            end
        end
    end
    assign o_result_code = code_q;
    assign o_state = state_q;

    // Independent reference-on count for the warm-up checks
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ref_run_q <= 32'h0;
        end else if (!o_ref_on) begin
            ref_run_q <= 32'h0;
        end else if (ref_run_q < WARMUP_CYCLES) begin
            ref_run_q <= ref_run_q + 32'h1;
        end
    end

    // Auto low-power entry, hold and exit
    chk_auto_after_conv: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_ACTIVE && i_conv_done && !sw_cmd && !hw_pd |=> state_q == ADCPD_AUTO)
        else $error("no auto low-power after conversion");
    chk_auto_stay: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_AUTO && !wake && !sw_cmd && !hw_pd |=> state_q == ADCPD_AUTO)
        else $error("auto low-power left without a wake");
    chk_auto_core_off: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_AUTO |-> !o_core_on)
        else $error("core on in auto low-power");
    chk_auto_ref_on: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_AUTO && !hw_pd |-> o_ref_on)
        else $error("reference off in auto low-power");
    chk_auto_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_AUTO && wake && !sw_cmd && !hw_pd |=> state_q == ADCPD_ACTIVE)
        else $error("auto low-power did not wake");
    chk_active_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_ACTIVE && !sw_cmd && !i_conv_done && !hw_pd |=> state_q == ADCPD_ACTIVE)
        else $error("active mode left without a cause");

    // Software power-down and external reference readiness
    chk_sw_cmd_off: assert property (@(posedge i_clock) disable iff (i_rst)
        sw_cmd && !hw_pd && state_q != ADCPD_SWPD |=> !o_ref_on && !o_core_on)
        else $error("software power-down not entered");
    chk_sw_from_auto: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_AUTO && sw_cmd && !hw_pd |=> state_q == ADCPD_SWPD)
        else $error("command ignored in auto low-power");
    chk_sw_from_hw: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_HWPD && sw_cmd && !hw_pd |=> state_q == ADCPD_SWPD)
        else $error("command ignored on pin release");
    chk_sw_ref_off: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_SWPD |-> !o_ref_on && !o_core_on)
        else $error("power on in software power-down");
    chk_sw_stay: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_SWPD && !wake && !hw_pd |=> state_q == ADCPD_SWPD)
        else $error("software power-down left without a wake");
    chk_sw_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_SWPD && wake && !hw_pd |=> state_q == ADCPD_ACTIVE)
        else $error("software power-down did not wake");
    chk_ext_ready: assert property (@(posedge i_clock) disable iff (i_rst)
        o_ref_on && cfg_q[ADCPD_CFG_REF_EXT_BIT] |-> o_ref_ready)
        else $error("external reference not ready at once");

    // Pin power-down
    chk_hw_pd_now: assert property (@(posedge i_clock) disable iff (i_rst)
        hw_pd |-> !o_ref_on && !o_core_on)
        else $error("pin power-down not immediate");
    chk_hw_enter: assert property (@(posedge i_clock) disable iff (i_rst)
        hw_pd |=> state_q == ADCPD_HWPD)
        else $error("pin power-down state not entered");
    chk_pd_pin_ref: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_HWPD |-> !o_ref_on && !o_core_on)
        else $error("power on in pin power-down state");
    chk_hw_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        hw_pd && wake |=> state_q == ADCPD_HWPD)
        else $error("wake honoured during pin power-down");
    chk_hw_release: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_HWPD && !hw_pd && !sw_cmd |=> state_q == ADCPD_ACTIVE)
        else $error("pin release did not restore");
    chk_hw_ready_wait: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_HWPD && !hw_pd && !cfg_q[ADCPD_CFG_REF_EXT_BIT] |=> !o_ref_ready)
        else $error("internal reference ready without warm-up");
    chk_ext_after_hw: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_HWPD && !hw_pd && !sw_cmd && cfg_q[ADCPD_CFG_REF_EXT_BIT] |=> o_ref_ready || hw_pd)
        else $error("external reference late after pin release");

    // Reference warm-up
    chk_warm_early: assert property (@(posedge i_clock) disable iff (i_rst)
        o_ref_on && !cfg_q[ADCPD_CFG_REF_EXT_BIT] && ref_run_q < WARMUP_CYCLES |-> !o_ref_ready)
        else $error("reference ready before warm-up");
    chk_warm_done: assert property (@(posedge i_clock) disable iff (i_rst)
        o_ref_on && ref_run_q >= WARMUP_CYCLES |-> o_ref_ready)
        else $error("reference not ready after warm-up");
    chk_ready_ref: assert property (@(posedge i_clock) disable iff (i_rst)
        o_ref_ready |-> o_ref_on)
        else $error("ready with reference off");

    // Clear and restart pulses
    chk_fifo_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        enter_pd |=> o_fifo_clear && o_sweep_restart ##1 !o_fifo_clear)
        else $error("fifo clear pulse wrong");
    chk_sw_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q == ADCPD_ACTIVE && sw_cmd && !hw_pd |=> o_fifo_clear)
        else $error("no fifo clear on software power-down");
    chk_pulse_cause: assert property (@(posedge i_clock) disable iff (i_rst)
        o_fifo_clear |-> is_full_pd(state_q) && !is_full_pd($past(state_q)))
        else $error("fifo clear without power-down entry");
    chk_pulse_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        !enter_pd |=> !o_fifo_clear)
        else $error("spurious fifo clear");
    chk_sweep_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
        o_sweep_restart |=> !o_sweep_restart)
        else $error("sweep restart longer than one cycle");

    // Configuration
    chk_cfg_keep: assert property (@(posedge i_clock) disable iff (i_rst)
        state_q != ADCPD_ACTIVE |=> $stable(cfg_q))
        else $error("configuration changed in power-down");
    chk_cfg_write: assert property (@(posedge i_clock) disable iff (i_rst)
        i_cfg_write && state_q == ADCPD_ACTIVE |=> o_configuration_register == $past(i_cfg_data))
        else $error("configuration write lost");
    chk_cfg_in_pd: assert property (@(posedge i_clock) disable iff (i_rst)
        i_cfg_write && state_q != ADCPD_ACTIVE |=> $stable(o_configuration_register))
        else $error("configuration written while powered down");
    chk_cfg_hold_nowr: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_cfg_write |=> $stable(o_configuration_register))
        else $error("configuration changed without a write");

    // Result clamp
    chk_over_range: assert property (@(posedge i_clock) disable iff (i_rst)
        i_conv_done && i_over_ref_high |=> o_result_code == ADCPD_CODE_FULL)
        else $error("over-range code wrong");
    chk_under_range: assert property (@(posedge i_clock) disable iff (i_rst)
        i_conv_done && !i_over_ref_high && i_under_ref_low |=> o_result_code == ADCPD_CODE_ZERO)
        else $error("under-range code wrong");
    chk_in_range_code: assert property (@(posedge i_clock) disable iff (i_rst)
        i_conv_done && !i_over_ref_high && !i_under_ref_low |=> o_result_code == $past(i_raw_code))
        else $error("in-range code wrong");
    chk_result_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_conv_done |=> $stable(o_result_code))
        else $error("result changed without a conversion");

    cov_auto: cover property (@(posedge i_clock) state_q == ADCPD_AUTO ##1 state_q == ADCPD_ACTIVE);
    cov_sw: cover property (@(posedge i_clock) state_q == ADCPD_SWPD ##1 state_q == ADCPD_ACTIVE);
    cov_hw: cover property (@(posedge i_clock) state_q == ADCPD_HWPD ##1 state_q == ADCPD_ACTIVE);
    cov_clear: cover property (@(posedge i_clock) o_fifo_clear ##1 state_q == ADCPD_ACTIVE);
    cov_warm: cover property (@(posedge i_clock) !o_ref_ready ##1 o_ref_ready && !cfg_q[ADCPD_CFG_REF_EXT_BIT]);
endmodule

// [test/adcpd_host.sv]
`timescale 1ns/1ps
module adcpd_host
    import adcpd_pkg::*;
(
    // Device status
    input wire logic i_clock,
    input wire logic [3:0] i_state,
    input wire logic i_ref_ready,
    // Wake pins and power-down pin
    output logic o_cs_n = 1'b1,
    output logic o_fs = 1'b0,
    output logic o_cst_n = 1'b1,
    output logic o_pd_n = 1'b1,
    // Commands and conversion data
    output logic o_cmd_v = 1'b0,
    output logic [15:0] o_cmd = 16'h0000,
    output logic o_cfg_w = 1'b0,
    output logic [11:0] o_cfg = 12'h000,
    output logic o_conv = 1'b0,
    output logic [11:0] o_raw = 12'h000,
    output logic o_over = 1'b0,
    output logic o_under = 1'b0
);
    integer seed = 32'hA4F8;
    logic [31:0] r;
    always @(negedge i_clock) begin
        r = $random(seed);
        o_cs_n <= r[3:0] != 4'h0;
        o_fs <= r[3:0] == 4'h1;
        o_cst_n <= r[3:0] != 4'h2;
        o_cmd_v <= r[3:0] == 4'h3;
        o_cmd <= r[9] ? ADCPD_CMD_SW_POWER_DOWN_INPUT : r[31:16];
        o_cfg_w <= r[3:0] == 4'h4;
        o_cfg <= r[27:16];
        // Conversions only in active mode once the reference is ready
        o_conv <= r[3:2] == 2'h2 && i_state == ADCPD_ACTIVE && i_ref_ready;
        o_raw <= r[27:16];
        o_over <= r[28];
        o_under <= r[29];
        if (r[8:4] == 5'h00) begin
            o_pd_n <= ~o_pd_n;
        end
    end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import adcpd_pkg::*;
    localparam int W = 16;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic cs_n, fs, cst_n, pd_n, cmd_v, cfg_w, conv, over, under, core_on, ref_on, rdy, fclr, swr, m_clr, m_ron;
    logic [15:0] cmd;
    logic [11:0] cfg_d, raw, cfg_q, res, m_cfg, m_res;
    logic [3:0] st, m_st, nx;
    int m_warm, n_mismatch = 0, cmp_count = 0;
    always #2 i_clock = ~i_clock;
    adcpd_host host (.i_clock, .i_state(st), .i_ref_ready(rdy), .o_cs_n(cs_n), .o_fs(fs), .o_cst_n(cst_n),
        .o_pd_n(pd_n), .o_cmd_v(cmd_v), .o_cmd(cmd), .o_cfg_w(cfg_w), .o_cfg(cfg_d), .o_conv(conv),
        .o_raw(raw), .o_over(over), .o_under(under));
    adcpd_ctrl #(.WARMUP_CYCLES(W)) DUT (.i_clock, .i_rst, .i_chip_select_n(cs_n), .i_frame_sync_strobe(fs),
        .i_conversion_start_input_n(cst_n), .i_power_down_input_n(pd_n), .i_cmd_valid(cmd_v),
        .i_cmd_word(cmd), .i_cfg_write(cfg_w), .i_cfg_data(cfg_d), .i_conv_done(conv), .i_raw_code(raw),
        .i_over_ref_high(over), .i_under_ref_low(under), .o_core_on(core_on), .o_ref_on(ref_on),
        .o_ref_ready(rdy), .o_fifo_clear(fclr), .o_sweep_restart(swr), .o_configuration_register(cfg_q),
        .o_result_code(res), .o_state(st));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reference model: compare old outputs first, then advance
    always @(posedge i_clock) begin
        m_ron = (m_st == ADCPD_ACTIVE || m_st == ADCPD_AUTO) && pd_n;
        if (!i_rst) begin
            check(12'(st), 12'(m_st));
            check(12'(core_on), 12'(m_st == ADCPD_ACTIVE && pd_n));
            check(12'(ref_on), 12'(m_ron));
            check(cfg_q, m_cfg);
            check(res, m_res);
            check({10'h000, fclr, swr}, {10'h000, m_clr, m_clr});
            check(12'(rdy), 12'(m_ron && (m_cfg[ADCPD_CFG_REF_EXT_BIT] || m_warm >= W)));
        end
        m_warm = (m_ron && !i_rst) ? m_warm + 1 : 0;
        nx = m_st;
        if (i_rst) begin
            nx = ADCPD_ACTIVE;
        end else if (!pd_n) begin
            nx = ADCPD_HWPD;
        end else if (cmd_v && cmd == ADCPD_CMD_SW_POWER_DOWN_INPUT && m_st != ADCPD_SWPD) begin
            nx = ADCPD_SWPD;
        end else if (m_st == ADCPD_HWPD) begin
            nx = ADCPD_ACTIVE;
        end else if (m_st == ADCPD_ACTIVE && conv) begin
            nx = ADCPD_AUTO;
        end else if (m_st != ADCPD_ACTIVE && (!cs_n || fs || !cst_n)) begin
            nx = ADCPD_ACTIVE;
        end
        if (cfg_w && m_st == ADCPD_ACTIVE) begin
            m_cfg = cfg_d;
        end
        if (conv) begin
            m_res = over ? ADCPD_CODE_FULL : under ? ADCPD_CODE_ZERO : raw;
        end
        m_clr = !i_rst && (nx == ADCPD_SWPD || nx == ADCPD_HWPD) && !(m_st == ADCPD_SWPD || m_st == ADCPD_HWPD);
        if (i_rst) begin
            m_cfg = ADCPD_CFG_RESET;
            m_res = 12'h000;
        end
        m_st = nx;
    end
    initial begin
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (10000) @(negedge i_clock);
        // Second reset in mid-run
        i_rst = 1'b1;
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (10000) @(negedge i_clock);
        stop_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule
